// *** hdlc_framer_pkg.sv ***
/*
  Constants and state types shared by the bit-level framer and its FIFOs.
  Assumes nothing of its surroundings; imported whole by every module but hdlc_line_model.
*/
package hdlc_framer_pkg;

  // ****************************************
  // line patterns and check field
  // ****************************************
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  // x^16 + x^12 + x^5 + 1, bit-reversed for lsb-first shifting
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;

  // ****************************************
  // counts
  // ****************************************
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] FLAG_RUN = 3'h6;
  localparam logic [4:0] ABORT_ONES = 5'h08;
  localparam logic [12:0] MAX_FRAME = 13'h1000;
  localparam logic [12:0] CRC_BYTES = 13'h0002;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 32;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [6:0] {
    TX_FILL = 7'h01, TX_OPEN = 7'h02, TX_DATA = 7'h04, TX_CRC = 7'h08,
    TX_CLOSE = 7'h10, TX_ABORT = 7'h20, TX_TRANSP = 7'h40
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_HUNT = 3'h1, RX_FRAME = 3'h2, RX_TRANSP = 3'h4
  } rx_state_e;

endpackage

// *** hdlc_framer.sv ***
/*
  Bit-level framer for one full-duplex serial channel: flags, zero
  insertion and deletion, check field, aborts, address filtering and a
  transparent bypass, with a word FIFO on each data path.
  Assumes both bit clocks and the receive data arrive from pins, run well
  below a quarter of clk_sys, and that the data changes away from the
  rising bit-clock edge.
*/
`timescale 1ns/100ps

module hdlc_fifo
  import hdlc_framer_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic flush,
  // fill side
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // drain side
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);
  // pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg, rptr_reg;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  assign push = wr_valid & wr_ready;
  assign pop = rd_ready & rd_valid;
  assign rd_data = mem_reg[rptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop & ~push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wptr_reg] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      wr_ready <= 1'b1;
      rd_valid <= 1'b0;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      wr_ready <= 1'b1;
      rd_valid <= 1'b0;
    end else begin
      wptr_reg <= wptr_reg + AW'(push);
      rptr_reg <= rptr_reg + AW'(pop);
      count_reg <= count_next;
      wr_ready <= count_next != (AW+1)'(DEPTH);
      rd_valid <= count_next != '0;
    end
  end
endmodule

module hdlc_framer
  import hdlc_framer_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // configuration levels
  input wire logic transparent_mode,
  input wire logic lapd_mode,
  input wire logic interframe_fill_select,
  input wire logic addr16,
  input wire logic ctrl16,
  input wire logic addr_filter_en,
  input wire logic [15:0] match_addr0,
  input wire logic [15:0] match_addr1,
  input wire logic [15:0] match_addr2,
  input wire logic tx_enable,
  input wire logic tx_force_abort,
  input wire logic rx_enable,
  // transmit words from memory
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_frame_done,
  // receive words to memory
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_frame_good,
  output logic rx_frame_bad,
  output logic rx_frame_abort,
  // serial line
  input wire logic tx_bit_clk,
  output logic tx_serial,
  input wire logic rx_bit_clk,
  input wire logic rx_serial
);
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b);
    crc_step = {1'b0, crc[15:1]} ^ ((crc[0] ^ b) ? CRC_POLY_REV : 16'h0000);
  endfunction

  function automatic logic addr_eq(input logic [15:0] a, input logic [15:0] m, input logic wide);
    addr_eq = wide ? (a == m) : (a[7:0] == m[7:0]);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic tclk_s1_reg, tclk_s2_reg, tclk_s3_reg;
  logic rclk_s1_reg, rclk_s2_reg, rclk_s3_reg;
  logic rdat_s1_reg, rdat_s2_reg;
  logic tx_tick, rx_tick;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {tclk_s1_reg, tclk_s2_reg, tclk_s3_reg} <= 3'h0;
      {rclk_s1_reg, rclk_s2_reg, rclk_s3_reg} <= 3'h0;
      {rdat_s1_reg, rdat_s2_reg} <= 2'h3;
    end else begin
      {tclk_s1_reg, tclk_s2_reg, tclk_s3_reg} <= {tx_bit_clk, tclk_s1_reg, tclk_s2_reg};
      {rclk_s1_reg, rclk_s2_reg, rclk_s3_reg} <= {rx_bit_clk, rclk_s1_reg, rclk_s2_reg};
      {rdat_s1_reg, rdat_s2_reg} <= {rx_serial, rdat_s1_reg};
    end
  end

  assign tx_tick = tclk_s2_reg & ~tclk_s3_reg;
  assign rx_tick = rclk_s2_reg & ~rclk_s3_reg;

  // ****************************************
  // FIFOs
  // ****************************************
  logic [8:0] tf_rdata, rf_wdata_reg, rf_rdata;
  logic tf_valid, tf_pop, rf_push_reg, rf_wready, rf_flush_reg;

  hdlc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk_sys(clk_sys), .reset_n(reset_n), .flush(1'b0),
    .wr_data({tx_last, tx_data}), .wr_valid(tx_valid), .wr_ready(tx_ready),
    .rd_data(tf_rdata), .rd_valid(tf_valid), .rd_ready(tf_pop)
  );

  hdlc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk_sys(clk_sys), .reset_n(reset_n), .flush(rf_flush_reg),
    .wr_data(rf_wdata_reg), .wr_valid(rf_push_reg), .wr_ready(rf_wready),
    .rd_data(rf_rdata), .rd_valid(rx_valid), .rd_ready(rx_ready)
  );

  assign rx_data = rf_rdata[7:0];
  assign rx_last = rf_rdata[8];

  // ****************************************
  // transmitter
  // ****************************************
  tx_state_e tx_state_reg;
  logic [15:0] tx_sh_reg, tx_crc_reg, tx_crc_next;
  logic [4:0] tx_cnt_reg;
  logic [2:0] tx_ones_reg;
  logic tx_last_reg, tx_skip_reg, tx_stuff, tx_load, tx_abort_req, tx_start, tx_fill_bit;

  assign tx_abort_req = tx_force_abort | ~tx_enable;
  assign tx_start = tf_valid & ~tx_skip_reg & tx_enable;
  // a check field ending in five 1s still needs its 0 before the closing flag
  assign tx_stuff = (tx_state_reg == TX_DATA || tx_state_reg == TX_CRC
    || (tx_state_reg == TX_CLOSE && tx_cnt_reg == 5'h00)) && tx_ones_reg == STUFF_RUN;
  assign tx_crc_next = crc_step(tx_crc_reg, tx_sh_reg[0]);
  // the D channel never fills with flags
  assign tx_fill_bit = (lapd_mode | interframe_fill_select) ? 1'b1 : FLAG_BYTE[tx_cnt_reg[2:0]];

  always_comb begin
    tx_load = 1'b0;
    if (tx_tick && !tx_stuff && tx_cnt_reg[2:0] == 3'h7) begin
      case (tx_state_reg)
        TX_FILL: tx_load = tx_start & transparent_mode;
        TX_OPEN: tx_load = ~tx_abort_req;
        TX_DATA: tx_load = ~tx_abort_req & ~tx_last_reg & tf_valid;
        TX_TRANSP: tx_load = tf_valid & transparent_mode;
        default: tx_load = 1'b0;
      endcase
    end
  end

  // after an abort the remainder of the broken frame is drained unsent
  assign tf_pop = tx_load | (tx_skip_reg & tf_valid);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg <= TX_FILL;
      tx_sh_reg <= 16'h0000;
      tx_crc_reg <= CRC_PRESET;
      tx_cnt_reg <= 5'h00;
      tx_ones_reg <= 3'h0;
      tx_last_reg <= 1'b0;
      tx_skip_reg <= 1'b0;
      tx_serial <= 1'b1;
      tx_frame_done <= 1'b0;
    end else begin
      tx_frame_done <= 1'b0;
      if (tx_skip_reg && tf_valid && tf_rdata[8]) begin
        tx_skip_reg <= 1'b0;
      end
      if (tx_load) begin
        tx_sh_reg <= {8'h00, tf_rdata[7:0]};
        tx_last_reg <= tf_rdata[8];
      end
      if (tx_tick && tx_stuff) begin
        tx_serial <= 1'b0;
        tx_ones_reg <= 3'h0;
      end else if (tx_tick) begin
        tx_cnt_reg <= tx_cnt_reg + 5'h01;
        case (tx_state_reg)
          TX_FILL: begin
            tx_serial <= tx_fill_bit;
            if (tx_cnt_reg[2:0] == 3'h7) begin
              tx_cnt_reg <= 5'h00;
              if (tx_start) begin
                tx_state_reg <= transparent_mode ? TX_TRANSP : TX_OPEN;
              end
            end
          end
          TX_OPEN, TX_CLOSE: begin
            tx_serial <= FLAG_BYTE[tx_cnt_reg[2:0]];
            tx_ones_reg <= 3'h0;
            tx_crc_reg <= CRC_PRESET;
            if (tx_state_reg == TX_OPEN && tx_abort_req) begin
              tx_state_reg <= TX_ABORT;
              tx_skip_reg <= 1'b1;
              tx_cnt_reg <= 5'h00;
            end else if (tx_cnt_reg[2:0] == 3'h7) begin
              tx_cnt_reg <= 5'h00;
              tx_state_reg <= (tx_state_reg == TX_OPEN) ? TX_DATA : TX_FILL;
              tx_frame_done <= tx_state_reg == TX_CLOSE;
            end
          end
          TX_DATA, TX_CRC: begin
            tx_serial <= tx_sh_reg[0];
            tx_ones_reg <= tx_sh_reg[0] ? tx_ones_reg + 3'h1 : 3'h0;
            if (!tx_load) begin
              tx_sh_reg <= {1'b0, tx_sh_reg[15:1]};
            end
            if (tx_state_reg == TX_DATA) begin
              tx_crc_reg <= tx_crc_next;
            end
            if (tx_abort_req) begin
              tx_state_reg <= TX_ABORT;
              tx_skip_reg <= tx_state_reg == TX_DATA && !tx_last_reg;
              tx_cnt_reg <= 5'h00;
            end else if (tx_state_reg == TX_DATA && tx_cnt_reg[2:0] == 3'h7) begin
              tx_cnt_reg <= 5'h00;
              if (tx_last_reg) begin
                tx_sh_reg <= ~tx_crc_next;
                tx_state_reg <= TX_CRC;
              end else if (!tf_valid) begin
                tx_state_reg <= TX_ABORT;
                tx_skip_reg <= 1'b1;
              end
            end else if (tx_state_reg == TX_CRC && tx_cnt_reg == 5'h0F) begin
              tx_cnt_reg <= 5'h00;
              tx_state_reg <= TX_CLOSE;
            end
          end
          TX_ABORT: begin
            // eight ones plus at most six before stays within fourteen
            tx_serial <= 1'b1;
            tx_ones_reg <= 3'h0;
            if (tx_cnt_reg == ABORT_ONES - 5'h01) begin
              tx_cnt_reg <= 5'h00;
              tx_state_reg <= TX_FILL;
            end
          end
          TX_TRANSP: begin
            tx_serial <= tx_sh_reg[0];
            if (!tx_load) begin
              tx_sh_reg <= {1'b1, tx_sh_reg[15:1]};
            end
            if (tx_cnt_reg[2:0] == 3'h7) begin
              tx_cnt_reg <= 5'h00;
              if (!transparent_mode) begin
                tx_state_reg <= TX_FILL;
              end else if (!tf_valid) begin
                tx_sh_reg <= 16'hFFFF;
              end
            end
          end
          default: tx_state_reg <= TX_FILL;
        endcase
      end
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  rx_state_e rx_state_reg;
  logic [6:0] rx_dly_reg;
  logic [2:0] rx_dcnt_reg, rx_ones_reg, rx_bit_reg;
  logic [15:0] rx_crc_reg;
  logic [7:0] rx_byte_reg, rx_pend_reg, rx_byte_new;
  logic [12:0] rx_nbytes_reg, rx_min;
  logic rx_pend_v_reg, rx_in_bit, rx_b, rx_addr_fail, rx_hit, rx_good, rx_any;

  // the delay hides the 0111111 of a closing flag or abort from the data
  assign rx_b = rdat_s2_reg;
  assign rx_in_bit = (rx_state_reg == RX_TRANSP) ? rx_b : rx_dly_reg[0];
  assign rx_byte_new = {rx_in_bit, rx_byte_reg[7:1]};
  assign rx_min = 13'(addr16) + 13'(ctrl16) + 13'h0002 + CRC_BYTES;
  assign rx_any = rx_nbytes_reg != 13'h0000 || rx_bit_reg != 3'h0;

  always_comb begin
    logic [15:0] a;
    a = addr16 ? {rx_byte_new, rx_pend_reg} : {8'h00, rx_byte_new};
    rx_hit = addr_eq(a, match_addr0, addr16) | addr_eq(a, match_addr1, addr16)
      | addr_eq(a, match_addr2, addr16);
    rx_addr_fail = addr_filter_en && !rx_hit && rx_nbytes_reg == 13'(addr16);
  end

  assign rx_good = rx_pend_v_reg && rx_bit_reg == 3'h0 && rx_crc_reg == CRC_GOOD
    && rx_nbytes_reg >= rx_min && rf_wready;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_reg <= RX_HUNT;
      rx_dly_reg <= 7'h00;
      rx_dcnt_reg <= 3'h0;
      rx_ones_reg <= 3'h0;
      rx_bit_reg <= 3'h0;
      rx_crc_reg <= CRC_PRESET;
      rx_byte_reg <= 8'h00;
      rx_pend_reg <= 8'h00;
      rx_pend_v_reg <= 1'b0;
      rx_nbytes_reg <= 13'h0000;
      rf_push_reg <= 1'b0;
      rf_wdata_reg <= 9'h000;
      rf_flush_reg <= 1'b0;
      rx_frame_good <= 1'b0;
      rx_frame_bad <= 1'b0;
      rx_frame_abort <= 1'b0;
    end else begin
      rf_push_reg <= 1'b0;
      rf_flush_reg <= 1'b0;
      rx_frame_good <= 1'b0;
      rx_frame_bad <= 1'b0;
      rx_frame_abort <= 1'b0;
      if (!rx_enable) begin
        rx_state_reg <= RX_HUNT;
        rx_ones_reg <= 3'h0;
      end else if (rx_tick) begin
        rx_ones_reg <= rx_b ? ((rx_ones_reg == 3'h7) ? 3'h7 : rx_ones_reg + 3'h1) : 3'h0;
        if (rx_state_reg == RX_TRANSP || transparent_mode) begin
          rx_state_reg <= transparent_mode ? RX_TRANSP : RX_HUNT;
          rx_byte_reg <= rx_byte_new;
          rx_bit_reg <= rx_bit_reg + 3'h1;
          if (rx_bit_reg == 3'h7 && rx_state_reg == RX_TRANSP) begin
            rf_wdata_reg <= {1'b0, rx_byte_new};
            rf_push_reg <= rf_wready;
          end
        end else if (rx_b && rx_ones_reg == FLAG_RUN) begin
          if (rx_state_reg == RX_FRAME) begin
            rf_flush_reg <= 1'b1;
            rx_frame_abort <= 1'b1;
          end
          rx_state_reg <= RX_HUNT;
        end else if (!rx_b && rx_ones_reg == FLAG_RUN) begin
          if (rx_state_reg == RX_FRAME && rx_good) begin
            rf_wdata_reg <= {1'b1, rx_pend_reg};
            rf_push_reg <= 1'b1;
            rx_frame_good <= 1'b1;
          end else if (rx_state_reg == RX_FRAME && rx_any) begin
            rf_flush_reg <= 1'b1;
            rx_frame_bad <= 1'b1;
          end
          rx_state_reg <= RX_FRAME;
          rx_dcnt_reg <= 3'h0;
          rx_bit_reg <= 3'h0;
          rx_nbytes_reg <= 13'h0000;
          rx_pend_v_reg <= 1'b0;
          rx_crc_reg <= CRC_PRESET;
        end else if (rx_state_reg == RX_FRAME && !(!rx_b && rx_ones_reg == STUFF_RUN)) begin
          rx_dly_reg <= {rx_b, rx_dly_reg[6:1]};
          if (rx_dcnt_reg != 3'h7) begin
            rx_dcnt_reg <= rx_dcnt_reg + 3'h1;
          end else begin
            rx_crc_reg <= crc_step(rx_crc_reg, rx_in_bit);
            rx_byte_reg <= rx_byte_new;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_nbytes_reg <= rx_nbytes_reg + 13'h0001;
              rx_pend_reg <= rx_byte_new;
              rx_pend_v_reg <= 1'b1;
              if (rx_addr_fail) begin
                rx_state_reg <= RX_HUNT;
              end else if (rx_nbytes_reg == MAX_FRAME + CRC_BYTES || (rx_pend_v_reg && !rf_wready)) begin
                rf_flush_reg <= 1'b1;
                rx_frame_bad <= 1'b1;
                rx_state_reg <= RX_HUNT;
              end else if (rx_pend_v_reg) begin
                rf_wdata_reg <= {1'b0, rx_pend_reg};
                rf_push_reg <= 1'b1;
              end
            end
          end
        end
      end
    end
  end
endmodule

// *** hdlc_framer_props.sv ***
/*
  Port-level checks for the bit-level framer.
  Assumes bit clocks far below clk_sys/4; attached by the bind at the foot.
*/
`timescale 1ns/100ps
module hdlc_framer_props
  import hdlc_framer_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // transmit side
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_frame_done,
  input wire logic tx_bit_clk,
  input wire logic tx_serial,
  // receive side
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_frame_good,
  input wire logic rx_frame_bad,
  input wire logic rx_frame_abort
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ****************************************
  // relations between ports
  // ****************************************
  a_reset_leaves_idle: assert property ($rose(reset_n) |-> tx_serial && tx_ready && !rx_valid)
    else $error("outputs not idle after reset");
  a_done_single: assert property (tx_frame_done |=> !tx_frame_done)
    else $error("frame done longer than one cycle");
  a_good_has_data: assert property (rx_frame_good |=> rx_valid)
    else $error("good frame left no data");
  a_abort_flushes: assert property (rx_frame_abort |-> ##[1:2] !rx_valid)
    else $error("abort did not flush");
  a_bad_flushes: assert property (rx_frame_bad |-> ##[1:2] !rx_valid)
    else $error("bad frame did not flush");
  a_single_verdict: assert property ($onehot0({rx_frame_good, rx_frame_bad, rx_frame_abort}))
    else $error("two frame verdicts at once");
  // a bit may only move while the synchronised bit clock is high
  a_bit_paced: assert property ($changed(tx_serial) |-> $past(tx_bit_clk, 2))
    else $error("serial bit moved off the bit clock");
  a_full_after_write: assert property ($fell(tx_ready) |-> $past(tx_valid) || $past(tx_valid, 2))
    else $error("ready fell without a write");
  a_head_holds: assert property (rx_valid && !rx_ready |=> (rx_valid && $stable({rx_data, rx_last}))
    || rx_frame_bad || rx_frame_abort || $past(rx_frame_bad) || $past(rx_frame_abort))
    else $error("receive head changed before pop");

  c_good: cover property (rx_frame_good);
  c_bad: cover property (rx_frame_bad);
  c_abort: cover property (rx_frame_abort);
  c_full: cover property ($fell(tx_ready));
endmodule

bind hdlc_framer hdlc_framer_props chk (.clk_sys(clk_sys), .reset_n(reset_n), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_frame_done(tx_frame_done), .tx_bit_clk(tx_bit_clk), .tx_serial(tx_serial),
  .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_frame_good(rx_frame_good), .rx_frame_bad(rx_frame_bad), .rx_frame_abort(rx_frame_abort));

// *** hdlc_line_model.sv ***
/*
  Far end of the serial line: a free-running bit clock, loopback or
  injected bits toward the receiver, and a watch on runs of 1s sent.
  Assumes the bench pushes injected bits into q.
*/
`timescale 1ns/100ps
module hdlc_line_model (
  // serial line
  input wire logic tx_serial,
  output logic bit_clk,
  output logic rx_serial,
  // bench controls and observations
  input wire logic loop_en,
  input wire logic clr_max,
  output logic [7:0] ones_run,
  output logic [7:0] max_ones
);
  bit q[$];

  // ****************************************
  // line clock and data
  // ****************************************
  // a synchronous line clock runs between frames too; offset keeps it off clk_sys edges
  initial begin
    bit_clk = 0;
    ones_run = 0;
    max_ones = 0;
    rx_serial = 1;
    #13;
    forever #400 bit_clk = ~bit_clk;
  end

  // data moves on the falling edge, half a bit away from the sampling edge
  always @(negedge bit_clk) begin
    ones_run = (tx_serial === 1'b1) ? ones_run + 8'(ones_run != 8'hFF) : 8'h00;
    max_ones = clr_max ? 8'h00 : (ones_run > max_ones ? ones_run : max_ones);
    rx_serial = q.size() ? q.pop_front() : (loop_en ? tx_serial : 1'b1);
  end
endmodule

// *** hdlc_bit_level_framer_test.sv ***
/*
  Self-checking bench for the framer: fill patterns, looped frames,
  address filter, FIFO full, underrun abort and injected faults.
  Assumes hdlc_line_model stands on the serial side.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module hdlc_bit_level_framer_test;
  import hdlc_framer_pkg::*;
  logic clk_sys, reset_n, ifs, lapd, a16, c16, filt, tx_en, tx_last, tx_valid, rx_ready, loop_en, clr_max, tmode;
  logic tx_ready, tx_frame_done, rx_last, rx_valid, rx_frame_good, rx_frame_bad, rx_frame_abort;
  logic bclk, tx_serial, rx_serial;
  logic [7:0] tx_data, rx_data, ones_run, max_ones;
  logic [15:0] ma0, ma1, ma2, f;
  logic [7:0] fq[$], rq[$], ex[$];
  logic lq[$];
  int bad_count, num_checks, good_n, bad_n, abort_n, run, e0;

  hdlc_framer dut (.clk_sys(clk_sys), .reset_n(reset_n), .transparent_mode(tmode), .lapd_mode(lapd),
    .interframe_fill_select(ifs), .addr16(a16), .ctrl16(c16), .addr_filter_en(filt), .match_addr0(ma0),
    .match_addr1(ma1), .match_addr2(ma2), .tx_enable(tx_en), .tx_force_abort(1'b0), .rx_enable(1'b1),
    .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_frame_done(tx_frame_done), .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_frame_good(rx_frame_good), .rx_frame_bad(rx_frame_bad),
    .rx_frame_abort(rx_frame_abort), .tx_bit_clk(bclk), .tx_serial(tx_serial), .rx_bit_clk(bclk),
    .rx_serial(rx_serial));
  hdlc_line_model line (.tx_serial(tx_serial), .bit_clk(bclk), .rx_serial(rx_serial), .loop_en(loop_en),
    .clr_max(clr_max), .ones_run(ones_run), .max_ones(max_ones));

  // ****************************************
  // clock, collector and helpers
  // ****************************************
  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end

  // pops with random stalls so the receive FIFO backs up now and then
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1 && rx_ready) begin
      rq.push_back(rx_data);
      lq.push_back(rx_last);
    end
    good_n += (rx_frame_good === 1'b1);
    bad_n += (rx_frame_bad === 1'b1);
    abort_n += (rx_frame_abort === 1'b1);
    #5 rx_ready = ($urandom % 4) != 0;
  end

  task automatic tick();
    @(posedge clk_sys);
    #5;
  endtask

  task automatic put(input logic [7:0] d, input logic l);
    int n = 0;
    tx_data = d;
    tx_last = l;
    tx_valid = 1;
    while (tx_ready !== 1'b1 && n < 20000) begin
      tick();
      n++;
    end
    bad_count += (n == 20000);
    tick();
  endtask

  task automatic wait_ev(input int lim);
    int i = 0;
    int s = good_n + bad_n + abort_n;
    while (good_n + bad_n + abort_n == s && i < lim) begin
      tick();
      i++;
    end
  endtask

  function automatic logic [15:0] fcs();
    logic [15:0] c = 16'hFFFF;
    foreach (fq[i]) for (int k = 0; k < 8; k++) c = (c[0] ^ fq[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return ~c;
  endfunction

  // puts a byte on the injected line lsb first, stuffing inside a frame
  task automatic lb(input logic [7:0] d, input bit st);
    for (int k = 0; k < 8; k++) begin
      line.q.push_back(d[k]);
      run = (st && d[k]) ? run + 1 : 0;
      if (run == 5) begin
        line.q.push_back(1'b0);
        run = 0;
      end
    end
  endtask

  task automatic fill_chk(input logic i, input logic l, input int lo, input int hi);
    ifs = i;
    lapd = l;
    repeat (320) tick();
    clr_max = 1;
    repeat (40) tick();
    clr_max = 0;
    repeat (640) tick();
    `CHK("fill run", 1'b1, max_ones >= lo && max_ones <= hi)
  endtask

  task automatic frame(input int n, input logic [7:0] a, input bit hold, input bit ok);
    int g = good_n;
    fq.delete();
    rq.delete();
    lq.delete();
    for (int i = 0; i < n; i++) fq.push_back(i == 0 ? a : (i == 2 ? 8'hFF : 8'($urandom)));
    f = fcs();
    ex = fq;
    ex.push_back(f[7:0]);
    ex.push_back(f[15:8]);
    tx_en = !hold;
    foreach (fq[i]) put(fq[i], i == n - 1);
    tx_valid = 0;
    if (hold) begin
      tick();
      `CHK("tx_ready full", 1'b0, tx_ready)
      tx_en = 1;
    end
    wait_ev(ok ? 20000 : 3000);
    for (int i = 0; i < 400 && rq.size() < ex.size() && ok; i++) tick();
    `CHK("good pulses", g + ok, good_n)
    `CHK("bytes", ok ? ex.size() : 0, rq.size())
    foreach (rq[i]) if (i < ex.size()) begin
      `CHK("rx_data", ex[i], rq[i])
      `CHK("rx_last", i == ex.size() - 1, lq[i])
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    #4000000;
    bad_count++;
    summarize();
  end

  initial begin
    {reset_n, tmode, ifs, lapd, a16, c16, filt, tx_valid, tx_last, clr_max, run} = '0;
    {tx_en, rx_ready, loop_en} = 3'h7;
    tx_data = 8'h00;
    ma0 = 16'h00A5;
    ma1 = 16'h0033;
    ma2 = 16'h0044;
    void'($urandom(32'h7E72));
    repeat (5) @(posedge clk_sys);
    #5 reset_n = 1;
    fill_chk(0, 0, 1, 6);
    fill_chk(1, 0, 16, 255);
    fill_chk(0, 1, 16, 255);
    lapd = 0;
    for (int m = 0; m < 4; m++) begin
      a16 = m[0];
      c16 = m[1];
      frame(2 + m[0] + m[1] + (m == 0 ? 0 : $urandom % 4), 8'($urandom), 0, 1);
    end
    {a16, c16, filt} = 3'h1;
    frame(4, 8'h44, 0, 1);
    frame(4, 8'h5A, 0, 0);
    filt = 0;
    frame(32, 8'($urandom), 1, 1);
    // underrun mid-frame, then the tagged word that closes the discarded frame
    clr_max = 1;
    repeat (40) tick();
    clr_max = 0;
    e0 = abort_n;
    put(8'h01, 0);
    put(8'h02, 0);
    put(8'h03, 0);
    tx_valid = 0;
    wait_ev(8000);
    `CHK("abort pulses", e0 + 1, abort_n)
    `CHK("abort ones", 1'b1, max_ones >= 7 && max_ones <= 14)
    put(8'h04, 1);
    tx_valid = 0;
    repeat (800) tick();
    // raw bytes both ways: 32 zeros with no flag or stuffing hold three or four whole bytes
    tmode = 1;
    repeat (300) tick();
    rq.delete();
    repeat (4) put(8'h00, 0);
    tx_valid = 0;
    repeat (1500) tick();
    run = 0;
    foreach (rq[i]) run += (rq[i] == 8'h00);
    `CHK("raw zero bytes", 1'b1, run >= 3 && run <= 4)
    tmode = 0;
    loop_en = 0;
    fq = {8'h3C, 8'hFF};
    f = fcs() ^ 16'h0001;
    e0 = bad_n;
    lb(8'h7E, 0);
    foreach (fq[i]) lb(fq[i], 1);
    lb(f[7:0], 1);
    lb(f[15:8], 1);
    lb(8'h7E, 0);
    wait_ev(3000);
    `CHK("bad pulses", e0 + 1, bad_n)
    e0 = abort_n;
    lb(8'h7E, 0);
    lb(8'h3C, 1);
    lb(8'hFF, 1);
    lb(8'hFF, 0);
    wait_ev(3000);
    `CHK("injected abort", e0 + 1, abort_n)
    summarize();
  end
endmodule
